// ===== dv/sbp_pins_model.sv
// sbp_pins_model: pads and external circuitry on the six port pins
// assumes the port's pad controls; the bench sets the external drivers
`timescale 1ns/100ps
`default_nettype none
module sbp_pins_model (
  input  wire logic       pclk,
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe,
  input  wire logic [3:0] weak_pullup_en,
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_val,
  output logic      [5:0] pin_lvl
);
  logic flt_q = 1'b0;

  // floating pads wander, so a stale level never passes for a real one
  always @(posedge pclk) begin
    flt_q <= ~flt_q;
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) begin
        pin_lvl[i] = pin_o[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if ((i < 4) && weak_pullup_en[i[1:0]]) begin
        pin_lvl[i] = 1'b1;
      end else begin
        pin_lvl[i] = flt_q ^ i[0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/sbp_port_tb_top.sv
// sbp_port_tb_top: register-level tests of the six-bit port over APB
// assumes sbp_pins_model for the pads; pin sync settles within 8 cycles
`timescale 1ns/100ps
`default_nettype none
module sbp_port_tb_top;
  import sbp_pkg::*;
  logic              pclk       = 1'b0;
  logic              presetn    = 1'b0;
  logic              ce         = 1'b1;
  logic              psel       = 1'b0;
  logic              penable    = 1'b0;
  logic              pwrite     = 1'b0;
  logic [ADDR_W-1:0] paddr      = '0;
  logic [31:0]       pwdata     = '0;
  logic              sleep_mode = 1'b0;
  logic              stop_mode  = 1'b0;
  logic [5:0]        ext_en     = '0;
  logic [5:0]        ext_val    = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [5:0]        pin_o;
  logic [5:0]        pin_oe;
  logic [5:0]        pin_lvl;
  logic [3:0]        wpu;
  logic [1:0]        spd;
  logic [1:0]        spu;
  logic              ext_reset_req;
  logic              irq;
  logic [31:0]       rd;
  logic              er;
  logic [7:0]        e;
  logic              t;
  logic              p;
  int                errors     = 0;
  int                tests_run  = 0;
  int                cyc        = 0;

  sbp_port sbp_port_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_lvl),
    .pin_o(pin_o), .pin_oe(pin_oe), .weak_pullup_en(wpu), .sbus_pulldown_en(spd),
    .sbus_pullup_en(spu), .sleep_mode(sleep_mode), .stop_mode(stop_mode),
    .ext_reset_req(ext_reset_req), .irq(irq));
  sbp_pins_model sbp_pins_model_i (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe),
    .weak_pullup_en(wpu), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));

  always #4 pclk = ~pclk;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // generous ceiling; the full run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR %0t: run hung", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sampled values are read before the edge's own updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  function automatic logic [11:0] bwin(input logic [2:0] idx, input logic [2:0] b);
    return OFF_BIT_BASE + {4'h0, idx, 5'h00} + {7'h00, b, 2'h0};
  endfunction

  initial begin
    wt(8);
    presetn <= 1'b1;
    chk(32'(pin_oe), 32'h0);
    chk(32'({spu, spd}), 32'h3);
    chk(32'(wpu), 32'h0);
    rdchk(OFF_DRIVE, 32'h3F);
    rdchk(OFF_PULLUP, 32'h0);
    rdchk(OFF_ALTF, 32'h0);
    rdchk(OFF_EIC, 32'h0);
    $display("test reset done");

    wr(OFF_DRIVE, 32'h3E);
    wt(2);
    chk(32'({pin_oe, pin_o}), 32'h70);
    sleep_mode <= 1'b1;
    wt(2);
    chk(32'(pin_oe), 32'h0);
    rdchk(OFF_DRIVE, 32'h3E);
    sleep_mode <= 1'b0;
    wt(2);
    chk(32'(pin_oe), 32'h1);
    $display("test drive done");

    wr(OFF_DRIVE, 32'h3F);
    wr(OFF_PULLUP, 32'h3F);
    wt(2);
    chk(32'(wpu), 32'hF);
    chk(32'({pin_oe, pin_o[5:4]}), 32'hC3);
    stop_mode <= 1'b1;
    wt(2);
    chk(32'(wpu), 32'hF);
    chk(32'(pin_oe), 32'h0);
    stop_mode <= 1'b0;
    wr(OFF_PULLUP, 32'h05);
    wt(2);
    chk(32'({pin_oe, wpu}), 32'h5);
    wr(bwin(IDX_DRIVE, 3'h0), 32'h0);
    wt(2);
    chk(32'({pin_oe, wpu}), 32'h14);
    wr(OFF_DRIVE, 32'h3F);
    $display("test pullup done");

    // external drivers now hold every pin; design released except for the pin 3 pulldown while drive bit 3 is cleared
    wr(OFF_PULLUP, 32'h0);
    ext_en  <= 6'h3F;
    ext_val <= 6'h2A;
    wt(8);
    rdchk(OFF_SAMPLED, 32'h2A);
    chk(32'(pin_oe), 32'h0);
    rdchk(bwin(IDX_SAMPLED, 3'h1), 32'h1);
    ce      <= 1'b0;
    ext_val <= 6'h15;
    wt(8);
    ce      <= 1'b1;
    rdchk(OFF_SAMPLED, 32'h2A);
    wt(8);
    rdchk(OFF_SAMPLED, 32'h15);
    ext_val <= 6'h2A;
    wr(bwin(IDX_DRIVE, 3'h3), 32'h0);
    rdchk(OFF_DRIVE, 32'h37);
    rdchk(bwin(IDX_DRIVE, 3'h3), 32'h0);
    wr(OFF_DRIVE, 32'h3F);
    apb(1'b0, 12'h800, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    wr(OFF_ALTF, 32'hFF);
    rdchk(OFF_ALTF, 32'h07);
    wt(8);
    chk(32'(ext_reset_req), 32'h1);
    wr(OFF_EIC, 32'h40);
    wt(2);
    chk(32'(ext_reset_req), 32'h0);
    $display("test access done");

    wr(OFF_MASK, 32'h3);
    for (int l = 0; l < 2; l++) begin
      for (int m = 0; m < 4; m++) begin
        t = m[1];
        p = m[0];
        e = 8'h00;
        e[l] = 1'b1;
        e[2+l] = t;
        e[4+l] = p;
        ext_val[l] <= ~p;
        wt(8);
        wr(OFF_EIC, {24'h0, e});
        wr(OFF_STATUS, 32'h3);
        rdchk(OFF_STATUS, 32'h0);
        ext_val[l] <= p;
        wt(8);
        rdchk(OFF_STATUS, 32'h1 << l);
        chk(32'(irq), 32'h1);
        wr(OFF_STATUS, 32'h3);
        wt(2);
        rdchk(OFF_STATUS, t ? 32'h0 : (32'h1 << l));
        ext_val[l] <= ~p;
        wt(8);
        wr(OFF_STATUS, 32'h3);
        wt(2);
        rdchk(OFF_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
      end
    end
    wr(OFF_EIC, 32'h0);
    wr(OFF_STATUS, 32'h3);
    ext_val[1:0] <= 2'b11;
    wt(8);
    ext_val[1:0] <= 2'b00;
    wt(8);
    rdchk(OFF_STATUS, 32'h0);
    wr(OFF_ALTF, 32'h06);
    wr(OFF_EIC, 32'h01);
    wr(OFF_STATUS, 32'h3);
    wt(8);
    rdchk(OFF_STATUS, 32'h0);
    wr(OFF_ALTF, 32'h07);
    wr(OFF_MASK, 32'h2);
    wt(8);
    rdchk(OFF_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    $display("test irq done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== rtl/sbp_pkg.sv
// sbp_pkg: register map, field positions and reset values of the six-bit port
// assumes a 32-bit APB slave with word-aligned registers, data in the low byte
package sbp_pkg;

  localparam int unsigned NUM_BITS      = 6;
  localparam int unsigned NUM_WEAK      = 4;
  localparam int unsigned NUM_ALT       = 3;
  localparam int unsigned NUM_IRQ       = 2;
  localparam int unsigned ADDR_W        = 12;

  // byte window: register index in paddr[4:2]
  localparam logic [2:0]  IDX_SAMPLED   = 3'h0;
  localparam logic [2:0]  IDX_DRIVE     = 3'h1;
  localparam logic [2:0]  IDX_PULLUP    = 3'h2;
  localparam logic [2:0]  IDX_ALTF      = 3'h3;
  localparam logic [2:0]  IDX_EIC       = 3'h4;
  localparam logic [2:0]  IDX_STATUS    = 3'h5;
  localparam logic [2:0]  IDX_MASK      = 3'h6;
  localparam logic [2:0]  IDX_SPAD      = 3'h7;
  localparam logic [11:0] OFF_SAMPLED   = 12'h000;
  localparam logic [11:0] OFF_DRIVE     = 12'h004;
  localparam logic [11:0] OFF_PULLUP    = 12'h008;
  localparam logic [11:0] OFF_ALTF      = 12'h00C;
  localparam logic [11:0] OFF_EIC       = 12'h010;
  localparam logic [11:0] OFF_STATUS    = 12'h014;
  localparam logic [11:0] OFF_MASK      = 12'h018;
  localparam logic [11:0] OFF_SPAD      = 12'h01C;
  // bit window: 0x100 + index*0x20 + bit*4, data in pwdata[0]
  localparam logic [3:0]  BIT_WIN_HI    = 4'h1;
  localparam logic [11:0] OFF_BIT_BASE  = 12'h100;

  // ext_irq_control fields
  localparam int unsigned EIC_EN_LSB    = 0;
  localparam int unsigned EIC_TYPE_LSB  = 2;
  localparam int unsigned EIC_POL_LSB   = 4;
  localparam int unsigned EIC_RSTOFF    = 6;
  // serial pad control fields
  localparam int unsigned SPAD_PD_LSB   = 0;
  localparam int unsigned SPAD_PU_LSB   = 2;

  localparam logic [7:0]  RST_DRIVE     = 8'h3F;
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam logic [7:0]  RST_SPAD      = 8'h03;
  localparam logic [7:0]  MASK_BITS     = 8'h3F;
  localparam logic [7:0]  MASK_ALTF     = 8'h07;
  localparam logic [7:0]  MASK_EIC      = 8'h7F;
  localparam logic [7:0]  MASK_IRQ      = 8'h03;
  localparam logic [7:0]  MASK_SPAD     = 8'h0F;

endpackage

// ===== rtl/sbp_port.sv
// sbp_port: six-bit port with two pin interrupts, APB register slave
// assumes pins are asynchronous to pclk; pad cells resolve pin_o/pin_oe and pullups
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - each bit configured independently, no coupling
// - registers reachable by byte and bit
// - sampled_levels read returns pin levels, no effect
// - drive_value 0: pulldown on, pullup off
// - drive_value 1: pulldown off, pullup if selected
// - drive_value set asynchronously at reset
// - sleep forces pulldowns off, values kept
// - no pulldown, no pullup: pin high impedance
// - selected weak pullup stays on in stop
// - bits 0-3 weak, 4-5 strong push-pull
// - alternate select only bits 0-2
// - reset_function_off write 1 disables reset input
// - ext_irq_control low six bits configure irqs
// - irq detection only while enabled
// - type 0: level, polarity picks low/high
// - type 1: edge, polarity picks fall/rise
// - reset: inputs, pullups off, serial pulldowns on
// - separate flags gated by alt and enable
module sbp_port
  import sbp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [5:0]        pin_i,
  output logic      [5:0]        pin_o,
  output logic      [5:0]        pin_oe,
  output logic      [3:0]        weak_pullup_en,
  output logic      [1:0]        sbus_pulldown_en,
  output logic      [1:0]        sbus_pullup_en,
  input  wire logic              sleep_mode,
  input  wire logic              stop_mode,
  output logic                   ext_reset_req,
  output logic                   irq
);

  logic [7:0]        drive_value_q;
  logic [7:0]        pullup_select_q;
  logic [7:0]        alt_function_select_q;
  logic [7:0]        ext_irq_control_q;
  logic [7:0]        irq_status_q;
  logic [7:0]        irq_mask_q;
  logic [7:0]        spad_ctrl_q;
  logic [5:0]        sync1_q;
  logic [5:0]        sync2_q;
  logic [5:0]        sync3_q;
  logic [5:0]        level_q;
  logic [5:0]        level_d;
  logic [5:0]        pin_o_q;
  logic [5:0]        pin_oe_q;
  logic [3:0]        weak_pu_q;
  logic [1:0]        irq_hit;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              ext_reset_req_q;
  logic              irq_q;

  // apb decode
  logic              setup_ph;
  logic              wr_acc;
  logic              bit_win;
  logic              byte_win;
  logic              mapped;
  logic [2:0]        reg_idx;
  logic [2:0]        bit_idx;
  logic [7:0]        wr_mask;
  logic [7:0]        wr_val;
  logic [7:0]        rd_byte;

  assign setup_ph = psel && !penable;
  assign wr_acc   = ce && psel && penable && pready_q && pwrite && !pslverr_q;
  assign byte_win = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  assign bit_win  = (paddr[11:8] == BIT_WIN_HI) && (paddr[1:0] == 2'h0);
  assign mapped   = byte_win || bit_win;
  assign reg_idx  = bit_win ? paddr[7:5] : paddr[4:2];
  assign bit_idx  = paddr[4:2];

  // byte write covers all bits, bit write one lane only
  always_comb begin
    if (bit_win) begin
      wr_mask = 8'h01 << bit_idx;
      wr_val  = {8{pwdata[0]}};
    end else begin
      wr_mask = 8'hFF;
      wr_val  = pwdata[7:0];
    end
  end

  always_comb begin
    unique case (reg_idx)
      IDX_SAMPLED: rd_byte = {2'b00, level_q};
      IDX_DRIVE:   rd_byte = drive_value_q;
      IDX_PULLUP:  rd_byte = pullup_select_q;
      IDX_ALTF:    rd_byte = alt_function_select_q;
      IDX_EIC:     rd_byte = ext_irq_control_q;
      IDX_STATUS:  rd_byte = irq_status_q;
      IDX_MASK:    rd_byte = irq_mask_q;
      IDX_SPAD:    rd_byte = spad_ctrl_q;
    endcase
  end

  // no wait state: data captured at setup, pready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q  <= setup_ph;
      if (setup_ph) begin
        pslverr_q <= !mapped;
        if (!mapped || pwrite) begin
          prdata_q <= 32'h0000_0000;
        end else if (bit_win) begin
          prdata_q <= {31'h0000_0000, rd_byte[bit_idx]};
        end else begin
          prdata_q <= {24'h00_0000, rd_byte};
        end
      end
    end
  end

  // masked byte update shared by the plain read/write registers
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic [7:0] m,
                                       input logic [7:0] v,
                                       input logic [7:0] keep);
    merge = ((cur & ~m) | (v & m)) & keep;
  endfunction

  // drive values preset without a clock so no pulldown glitches at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_value_q <= RST_DRIVE;
    end else if (wr_acc && reg_idx == IDX_DRIVE) begin
      drive_value_q <= merge(drive_value_q, wr_mask, wr_val, MASK_BITS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_select_q <= RST_ZERO;
    end else if (wr_acc && reg_idx == IDX_PULLUP) begin
      pullup_select_q <= merge(pullup_select_q, wr_mask, wr_val, MASK_BITS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_function_select_q <= RST_ZERO;
    end else if (wr_acc && reg_idx == IDX_ALTF) begin
      alt_function_select_q <= merge(alt_function_select_q, wr_mask, wr_val, MASK_ALTF);
    end
  end

  // reset_function_off only sets; cleared by reset alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_control_q <= RST_ZERO;
    end else if (wr_acc && reg_idx == IDX_EIC) begin
      ext_irq_control_q[5:0] <= (ext_irq_control_q[5:0] & ~wr_mask[5:0])
                                | (wr_val[5:0] & wr_mask[5:0]);
      ext_irq_control_q[EIC_RSTOFF] <= ext_irq_control_q[EIC_RSTOFF]
                                       | (wr_mask[EIC_RSTOFF] & wr_val[EIC_RSTOFF]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= RST_ZERO;
    end else if (wr_acc && reg_idx == IDX_MASK) begin
      irq_mask_q <= merge(irq_mask_q, wr_mask, wr_val, MASK_IRQ);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spad_ctrl_q <= RST_SPAD;
    end else if (wr_acc && reg_idx == IDX_SPAD) begin
      spad_ctrl_q <= merge(spad_ctrl_q, wr_mask, wr_val, MASK_SPAD);
    end
  end

  // three-stage sampler; a level is taken once stages two and three agree
  // stage one may go metastable, so only stage two ever reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sync3_q <= 6'h00;
      level_q <= 6'h00;
    end else if (ce) begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  always_comb begin
    level_d = level_q;
    for (int i = 0; i < NUM_BITS; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        level_d[i] = sync3_q[i];
      end
    end
  end

  // per-bit pad drive, each bit from its own register bits only
  for (genvar g = 0; g < NUM_BITS; g++) begin : g_pad
    logic alt_on;
    logic nch_on;
    logic pu_on;
    assign alt_on = (g < NUM_ALT) ? alt_function_select_q[g] : 1'b0;
    // alternate functions here are all inputs, so the pulldown is released
    assign nch_on = !drive_value_q[g] && !sleep_mode && !alt_on;
    // pullup follows the drive bit, so sleep never turns a low into a pull-high
    assign pu_on  = drive_value_q[g] && pullup_select_q[g];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_o_q[g]  <= 1'b0;
        pin_oe_q[g] <= 1'b0;
      end else if (ce) begin
        if (g < NUM_WEAK) begin
          pin_o_q[g]  <= 1'b0;
          pin_oe_q[g] <= nch_on;
        end else begin
          // strong pullup drives high; shed in stop to save current
          pin_o_q[g]  <= !nch_on;
          pin_oe_q[g] <= nch_on || (pu_on && !stop_mode);
        end
      end
    end
    if (g < NUM_WEAK) begin : g_weak
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          weak_pu_q[g] <= 1'b0;
        end else if (ce) begin
          // stop_mode deliberately not in this term
          weak_pu_q[g] <= pu_on;
        end
      end
    end
  end

  // interrupt detection per line
  for (genvar k = 0; k < NUM_IRQ; k++) begin : g_irq
    logic en;
    logic typ;
    logic pol;
    assign en  = ext_irq_control_q[EIC_EN_LSB + k] && alt_function_select_q[k];
    assign typ = ext_irq_control_q[EIC_TYPE_LSB + k];
    assign pol = ext_irq_control_q[EIC_POL_LSB + k];
    always_comb begin
      if (!en) begin
        irq_hit[k] = 1'b0;
      end else if (!typ) begin
        irq_hit[k] = (level_q[k] == pol);
      end else begin
        irq_hit[k] = (level_d[k] != level_q[k]) && (level_d[k] == pol);
      end
    end
  end

  // a hit in the clearing cycle wins; a held level re-raises the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= RST_ZERO;
    end else if (ce) begin
      irq_status_q <= ((irq_status_q
                       & ~((wr_acc && reg_idx == IDX_STATUS) ? (wr_mask & wr_val) : 8'h00))
                       | {6'h00, irq_hit}) & MASK_IRQ;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q           <= 1'b0;
      ext_reset_req_q <= 1'b0;
    end else if (ce) begin
      irq_q           <= |(irq_status_q & irq_mask_q);
      ext_reset_req_q <= alt_function_select_q[2] && !ext_irq_control_q[EIC_RSTOFF]
                         && !level_q[2];
    end
  end

  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign pin_o            = pin_o_q;
  assign pin_oe           = pin_oe_q;
  assign weak_pullup_en   = weak_pu_q;
  assign sbus_pulldown_en = spad_ctrl_q[SPAD_PD_LSB +: 2];
  assign sbus_pullup_en   = spad_ctrl_q[SPAD_PU_LSB +: 2];
  assign ext_reset_req    = ext_reset_req_q;
  assign irq              = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_read_level: assert property (
    ce && setup_ph && !pwrite && paddr == OFF_SAMPLED |=> prdata_q[5:0] == $past(level_q))
    else $error("sampled read does not match pin levels");
  a_pulldown_on: assert property (
    ce && !sleep_mode && drive_value_q[3:0] == 4'h0 && alt_function_select_q[2:0] == 3'h0
    |=> pin_oe_q[3:0] == 4'hF && pin_o_q[3:0] == 4'h0 && weak_pu_q == 4'h0)
    else $error("zero drive value did not pull pins low");
  a_pullup_gate: assert property (
    ce |=> (weak_pu_q & ~$past(pullup_select_q[3:0])) == 4'h0)
    else $error("weak pullup on without its select bit");
  a_sleep_nch_off: assert property (
    ce && sleep_mode |=> pin_oe_q[3:0] == 4'h0)
    else $error("pulldown active in sleep");
  a_hiz_pin: assert property (
    ce && drive_value_q[3] && !pullup_select_q[3] |=> !pin_oe_q[3] && !weak_pu_q[3])
    else $error("pin not high impedance");
  a_irq_disabled: assert property (
    ce && !ext_irq_control_q[0] && !irq_status_q[0] |=> !irq_status_q[0])
    else $error("flag set while detection disabled");
  a_level_low: assert property (
    ce && ext_irq_control_q[5:0] == 6'h01 && alt_function_select_q[0] && !level_q[0]
    |=> irq_status_q[0] ##1 irq_status_q[0] || !ce)
    else $error("low level did not raise flag");
  a_edge_rise: assert property (
    ce && ext_irq_control_q[5:0] == 6'h15 && alt_function_select_q[0]
    && !level_q[0] && level_d[0] |=> irq_status_q[0])
    else $error("rising edge missed");
  a_irq_out: assert property (
    ce && (irq_status_q & irq_mask_q) != 8'h00 |=> irq_q)
    else $error("unmasked flag did not raise irq");
  a_reset_off: assert property (
    ce && ext_irq_control_q[EIC_RSTOFF] |=> !ext_reset_req_q)
    else $error("reset request after reset function off");
  a_status_sticky: assert property (
    ce && irq_status_q[1] && !(wr_acc && reg_idx == IDX_STATUS && wr_mask[1] && wr_val[1])
    |=> irq_status_q[1])
    else $error("status flag lost without a clear");
  a_edge_fall: assert property (
    ce && ext_irq_control_q[1] && ext_irq_control_q[3] && !ext_irq_control_q[5]
    && alt_function_select_q[1] && level_q[1] && !level_d[1] |=> irq_status_q[1])
    else $error("falling edge missed");
  a_strong_stop: assert property (
    ce && stop_mode && drive_value_q[5:4] == 2'h3 |=> pin_oe_q[5:4] == 2'h0)
    else $error("strong pullup active in stop");
  a_unmapped_err: assert property (
    ce && setup_ph && !mapped |=> pslverr_q && pready_q)
    else $error("unmapped access not refused");
  a_alt_gate: assert property (
    ce && !alt_function_select_q[0] && !irq_status_q[0] |=> !irq_status_q[0])
    else $error("flag set with alternate function off");

  c_edge_irq: cover property (ce && irq_hit[1] && ext_irq_control_q[3]);
  c_bit_write: cover property (wr_acc && bit_win);
  c_irq_out: cover property ($rose(irq_q));
  c_level_irq: cover property (ce && irq_hit[0] && !ext_irq_control_q[2]);
  c_sleep_low: cover property (ce && sleep_mode && !drive_value_q[0]);

endmodule

`default_nettype wire
